// >>> verilog/gso_regs.sv
// status word, cycle counter and estimation output registers of the gauge
//
// Notes on behaviour
// - outputs read zero until 351 ms after configuration
// - capacity words unsigned, 5.0 uVh per sense-resistance
// - percent words step 1/256 percent, whole-percent upper byte
// - voltage words unsigned, LSB 1.25 mV over 16
// - current words signed, LSB 1.5625 uV
// - temperature signed, 1/256 degree, upper byte whole degrees
// - resistance words unsigned, LSB 1/4096 ohm
// - time words unsigned, LSB 5.625 seconds
// - cycle counter adds one per percent, saturates
// - reset flag D1 set on any reset
// - current low D2, high D6 alert flags
// - voltage low D8, high D12 alert flags
// - temperature low D9, high D13 alert flags
// - charge low D10, high D14 alert flags
// - D3 shows battery absent level
// - D7 set on whole-percent charge crossing
// - D11 set on battery insertion, sticky
// - D15 set on battery removal, sticky
// - D0, D4, D5 undefined; here read zero
// - per-group latching bit selects sticky or auto-clear
// - alert enable gates only the alert pin
`timescale 1ns/10ps
`include "gso_map.svh"
module gso_regs #(
   parameter int unsigned VALID_CYC = `GSO_VALID_CYC
) (
   input  wire logic            mclk_i,
   input  wire logic            rstn_i,
   input  wire logic            sw_reset_i,
   input  wire logic [7:0]      reg_addr_i,
   input  wire logic            reg_wr_i,
   input  wire logic            reg_rd_i,
   input  wire gso_pkg::gso_word_t reg_wdata_i,
   output gso_pkg::gso_word_t   reg_rdata_o,
   output logic                 reg_rvalid_o,
   input  wire logic            config_done_i,
   input  wire gso_pkg::gso_word_t est_cap_i,
   input  wire gso_pkg::gso_word_t est_soc_i,
   input  wire gso_pkg::gso_word_t est_fullcap_i,
   input  wire gso_pkg::gso_word_t est_tte_i,
   input  wire gso_pkg::gso_word_t est_ttf_i,
   input  wire logic            cycle_pct_step_i,
   input  wire logic            meas_valid_i,
   input  wire gso_pkg::gso_word_t current_i,
   input  wire gso_pkg::gso_word_t cell_voltage_reading_i,
   input  wire gso_pkg::gso_word_t temp_i,
   input  wire gso_pkg::gso_word_t current_alert_limits_i,
   input  wire gso_pkg::gso_word_t voltage_alert_limits_i,
   input  wire gso_pkg::gso_word_t temperature_alert_limits_i,
   input  wire gso_pkg::gso_word_t charge_alert_limits_i,
   input  wire logic            current_alert_latching_i,
   input  wire logic            voltage_alert_latching_i,
   input  wire logic            temp_alert_latching_i,
   input  wire logic            charge_alert_latching_i,
   input  wire logic            alert_enable_i,
   input  wire logic            analog_sense_pin_i,
   output logic                 alert_output_pin_o,
   output logic                 outputs_valid_o
);
   import gso_pkg::*;

   // ****************************************
   // reset release
   // ****************************************
   logic rst_meta;
   logic rst_n;
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // ****************************************
   // helpers
   // ****************************************
   // upper byte of reading against one limit byte; signed for current and temp
   function automatic logic below(input logic [7:0] v, input logic [7:0] lim, input logic sgn);
      below = sgn ? ($signed(v) < $signed(lim)) : (v < lim);
   endfunction : below

   function automatic logic above(input logic [7:0] v, input logic [7:0] lim, input logic sgn);
      above = sgn ? ($signed(v) > $signed(lim)) : (v > lim);
   endfunction : above

   // ****************************************
   // output validity after configuration
   // ****************************************
   gso_valid_e vstate;
   logic [31:0] settle_cnt;
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         vstate     <= GSO_UNCONF;
         settle_cnt <= 32'h0000_0000;
      end else begin
         case (vstate)
            GSO_UNCONF: begin
               settle_cnt <= 32'h0000_0000;
               if (config_done_i) begin
                  vstate <= GSO_SETTLE;
               end
            end
            GSO_SETTLE: begin
               settle_cnt <= settle_cnt + 32'h0000_0001;
               if (settle_cnt == VALID_CYC - 1) begin
                  vstate <= GSO_VALID;
               end
            end
            GSO_VALID: begin
               settle_cnt <= settle_cnt;
            end
            default: begin
               vstate <= GSO_UNCONF;
            end
         endcase
      end
   end
   wire logic est_ok = (vstate == GSO_VALID);

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         outputs_valid_o <= 1'b0;
      end else begin
         outputs_valid_o <= est_ok;
      end
   end

   // ****************************************
   // cycle counter
   // ****************************************
   gso_word_t cycle_count;
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         cycle_count <= 16'h0000;
      end else if (cycle_pct_step_i && cycle_count != `GSO_CYCLES_MAX) begin
         cycle_count <= cycle_count + 16'h0001;
      end
   end

   // ****************************************
   // event detection
   // ****************************************
   // analog sense pin high means no cell in the pack slot
   logic ain_q;
   logic [7:0] soc_pct_q;
   logic soc_seen;
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         ain_q     <= 1'b0;
         soc_pct_q <= 8'h00;
         soc_seen  <= 1'b0;
      end else begin
         ain_q <= analog_sense_pin_i;
         if (est_ok) begin
            soc_pct_q <= est_soc_i[15:8];
            soc_seen  <= 1'b1;
         end
      end
   end
   wire logic ev_ins  = ain_q && !analog_sense_pin_i;
   wire logic ev_rem  = !ain_q && analog_sense_pin_i;
   wire logic ev_step = est_ok && soc_seen && (est_soc_i[15:8] != soc_pct_q);

   // threshold conditions, sampled on each measurement strobe
   logic [7:0] cond_lo;
   logic [7:0] cond_hi;
   always_comb begin
      cond_lo = 8'h00;
      cond_hi = 8'h00;
      cond_lo[0] = below(current_i[15:8], current_alert_limits_i[7:0], 1'b1);
      cond_hi[0] = above(current_i[15:8], current_alert_limits_i[15:8], 1'b1);
      cond_lo[1] = below(cell_voltage_reading_i[15:8], voltage_alert_limits_i[7:0], 1'b0);
      cond_hi[1] = above(cell_voltage_reading_i[15:8], voltage_alert_limits_i[15:8], 1'b0);
      cond_lo[2] = below(temp_i[15:8], temperature_alert_limits_i[7:0], 1'b1);
      cond_hi[2] = above(temp_i[15:8], temperature_alert_limits_i[15:8], 1'b1);
      cond_lo[3] = below(est_soc_i[15:8], charge_alert_limits_i[7:0], 1'b0);
      cond_hi[3] = above(est_soc_i[15:8], charge_alert_limits_i[15:8], 1'b0);
   end

   // ****************************************
   // status word
   // ****************************************
   gso_word_t status;
   gso_word_t next_status;
   gso_word_t set_v;
   gso_word_t keep_v;
   logic [3:0] latch_v;
   logic       st_wr;
   assign st_wr   = reg_wr_i && (reg_addr_i == `GSO_OFS_STATUS);
   assign latch_v = {charge_alert_latching_i, temp_alert_latching_i,
                     voltage_alert_latching_i, current_alert_latching_i};

   always_comb begin
      set_v  = 16'h0000;
      keep_v = st_wr ? (reg_wdata_i | ~`GSO_STATUS_RW) : 16'hFFFF;
      set_v[`GSO_B_POR]  = sw_reset_i;
      set_v[`GSO_B_DSOC] = ev_step;
      set_v[`GSO_B_BI]   = ev_ins;
      set_v[`GSO_B_BR]   = ev_rem;
      if (meas_valid_i) begin
         set_v[`GSO_B_IMN] = cond_lo[0];
         set_v[`GSO_B_IMX] = cond_hi[0];
         set_v[`GSO_B_VMN] = cond_lo[1];
         set_v[`GSO_B_VMX] = cond_hi[1];
         set_v[`GSO_B_TMN] = cond_lo[2];
         set_v[`GSO_B_TMX] = cond_hi[2];
         set_v[`GSO_B_SMN] = cond_lo[3];
         set_v[`GSO_B_SMX] = cond_hi[3];
         // auto-clear groups drop once the limit is no longer crossed
         if (!latch_v[0]) keep_v[`GSO_B_IMN] = 1'b0;
         if (!latch_v[0]) keep_v[`GSO_B_IMX] = 1'b0;
         if (!latch_v[1]) keep_v[`GSO_B_VMN] = 1'b0;
         if (!latch_v[1]) keep_v[`GSO_B_VMX] = 1'b0;
         if (!latch_v[2]) keep_v[`GSO_B_TMN] = 1'b0;
         if (!latch_v[2]) keep_v[`GSO_B_TMX] = 1'b0;
         if (!latch_v[3]) keep_v[`GSO_B_SMN] = 1'b0;
         if (!latch_v[3]) keep_v[`GSO_B_SMX] = 1'b0;
      end
      // set wins over a clear in the same cycle
      next_status = (status & keep_v) | set_v;
      next_status[`GSO_B_BST] = analog_sense_pin_i;
      next_status[0] = 1'b0;
      next_status[4] = 1'b0;
      next_status[5] = 1'b0;
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         status <= `GSO_STATUS_RST;
      end else begin
         status <= next_status;
      end
   end

   // ****************************************
   // alert pin
   // ****************************************
   wire logic thr_any = |(status & 16'h7744);
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         alert_output_pin_o <= 1'b0;
      end else begin
         alert_output_pin_o <= alert_enable_i && thr_any;
      end
   end

   // ****************************************
   // read port
   // ****************************************
   // estimation words pass through unscaled; their units are fixed upstream
   gso_word_t rd_mux; // every word is 16 bits, resistance words included
   always_comb begin
      case (reg_addr_i)
         `GSO_OFS_STATUS:  rd_mux = status;
         `GSO_OFS_REPORTED_REMAINING_CAPACITY:  rd_mux = est_ok ? est_cap_i : 16'h0000;
         `GSO_OFS_REPORTED_CHARGE_PERCENT:  rd_mux = est_ok ? est_soc_i : 16'h0000;
         `GSO_OFS_FULLCAP: rd_mux = est_ok ? est_fullcap_i : 16'h0000;
         `GSO_OFS_TTE:     rd_mux = est_ok ? est_tte_i : 16'h0000;
         `GSO_OFS_CYCLES:  rd_mux = cycle_count;
         `GSO_OFS_TTF:     rd_mux = est_ok ? est_ttf_i : 16'h0000;
         default:          rd_mux = 16'h0000;
      endcase
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_o  <= 16'h0000;
         reg_rvalid_o <= 1'b0;
      end else begin
         reg_rvalid_o <= reg_rd_i;
         if (reg_rd_i) begin
            reg_rdata_o <= rd_mux;
         end
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n);

   chk_unconf_zero: assert property ((reg_rd_i && !est_ok && reg_addr_i != `GSO_OFS_STATUS
                                      && reg_addr_i != `GSO_OFS_CYCLES) |=> reg_rdata_o == 16'h0000)
      else $error("output word visible before settle time");
   chk_settle_done: assert property ((vstate == GSO_SETTLE && settle_cnt == VALID_CYC - 1) |=> est_ok)
      else $error("outputs not valid after settle time");
   chk_cycle_step: assert property ((cycle_pct_step_i && cycle_count < 16'h00FF) |=> cycle_count == $past(cycle_count) + 16'h0001)
      else $error("cycle counter missed a step");
   chk_por_sw: assert property (sw_reset_i |=> status[`GSO_B_POR])
      else $error("reset flag not set");
   chk_dc_zero: assert property (##1 (status[0] == 1'b0 && status[4] == 1'b0 && status[5] == 1'b0))
      else $error("undefined status bits not zero");
   chk_bst_follow: assert property (##1 status[`GSO_B_BST] == $past(analog_sense_pin_i))
      else $error("absent flag does not track pin");
   chk_ins_sticky: assert property ((status[`GSO_B_BI] && !st_wr) |=> status[`GSO_B_BI])
      else $error("insertion flag dropped without a write");
   chk_rem_set: assert property ((!ain_q && analog_sense_pin_i) |=> status[`GSO_B_BR])
      else $error("removal flag not set");
   chk_step_set: assert property (ev_step |=> status[`GSO_B_DSOC])
      else $error("charge step flag not set");
   chk_imx_set: assert property ((meas_valid_i && cond_hi[0]) |=> status[`GSO_B_IMX])
      else $error("current high flag not set");
   chk_vmn_auto: assert property ((meas_valid_i && !cond_lo[1] && !voltage_alert_latching_i) |=> !status[`GSO_B_VMN])
      else $error("voltage low flag did not auto-clear");
   chk_wr_clear: assert property ((st_wr && !reg_wdata_i[`GSO_B_TMX] && !meas_valid_i) |=> !status[`GSO_B_TMX])
      else $error("written zero did not clear flag");
   chk_smx_latch: assert property ((status[`GSO_B_SMX] && charge_alert_latching_i && !st_wr) |=> status[`GSO_B_SMX])
      else $error("latched charge flag dropped");
   chk_alert_gate: assert property (!alert_enable_i |=> !alert_output_pin_o)
      else $error("alert pin driven while disabled");
   cov_valid: cover property (vstate == GSO_SETTLE ##1 est_ok);
   cov_insert: cover property (ev_ins ##[1:20] st_wr);
   cov_alert: cover property (alert_output_pin_o);
   cov_step: cover property (ev_step);
endmodule : gso_regs

// >>> verilog/gso_map.svh
// register offsets, status bit positions, reset values and timing counts
`ifndef GSO_MAP_SVH
`define GSO_MAP_SVH
`define GSO_OFS_STATUS   8'h00
`define GSO_OFS_REPORTED_REMAINING_CAPACITY   8'h05
`define GSO_OFS_REPORTED_CHARGE_PERCENT   8'h06
`define GSO_OFS_FULLCAP  8'h10
`define GSO_OFS_TTE      8'h11
`define GSO_OFS_CYCLES   8'h17
`define GSO_OFS_TTF      8'h20
`define GSO_STATUS_RST   16'h0002
`define GSO_B_POR        1
`define GSO_B_IMN        2
`define GSO_B_BST        3
`define GSO_B_IMX        6
`define GSO_B_DSOC       7
`define GSO_B_VMN        8
`define GSO_B_TMN        9
`define GSO_B_SMN        10
`define GSO_B_BI         11
`define GSO_B_VMX        12
`define GSO_B_TMX        13
`define GSO_B_SMX        14
`define GSO_B_BR         15
`define GSO_STATUS_RW    16'hFFC6
`define GSO_CYCLES_MAX   16'hFFFF
`define GSO_VALID_MS     351
`define GSO_CLK_KHZ      125000
`define GSO_VALID_CYC    (`GSO_VALID_MS * `GSO_CLK_KHZ)
`endif

// >>> verilog/gso_pkg.sv
// types shared by the status and output register bank
package gso_pkg;
   typedef enum logic [1:0] {
      GSO_UNCONF,
      GSO_SETTLE,
      GSO_VALID
   } gso_valid_e;
   typedef logic [15:0] gso_word_t;
endpackage : gso_pkg

// >>> verif/gso_host_model.sv
// host processor model driving the gauge register word port
`timescale 1ns/10ps
module gso_host_model (
   input  wire logic               mclk_i,
   input  wire gso_pkg::gso_word_t reg_rdata_i,
   input  wire logic               reg_rvalid_i,
   output logic [7:0]              reg_addr_o,
   output logic                    reg_wr_o,
   output logic                    reg_rd_o,
   output gso_pkg::gso_word_t      reg_wdata_o
);
   import gso_pkg::*;
   // ****************
   // access tasks
   // ****************
   initial begin
      reg_addr_o  = 8'h00;
      reg_wr_o    = 1'b0;
      reg_rd_o    = 1'b0;
      reg_wdata_o = 16'h0000;
   end
   task automatic write_word(input logic [7:0] addr, input gso_word_t data);
      @(negedge mclk_i);
      reg_addr_o  = addr;
      reg_wdata_o = data;
      reg_wr_o    = 1'b1;
      @(negedge mclk_i);
      reg_wr_o    = 1'b0;
      reg_wdata_o = ~data;  // stale bus data must never look valid
   endtask : write_word
   task automatic read_word(input logic [7:0] addr, output gso_word_t data);
      @(negedge mclk_i);
      reg_addr_o = addr;
      reg_rd_o   = 1'b1;
      @(negedge mclk_i);
      reg_rd_o   = 1'b0;
      data       = (reg_rvalid_i === 1'b1) ? reg_rdata_i : 16'hXXXX;
   endtask : read_word
   // event flags zeroed, all others written as one so they survive
   task automatic ack_events();
      write_word(8'h00, 16'h777D);
   endtask : ack_events
endmodule : gso_host_model

// >>> verif/gso_regs_test.sv
// self-checking bench for the gauge status and output register bank
`timescale 1ns/10ps
`include "gso_map.svh"
`define CHK(W, E, G) begin checks_done++; if ((G) !== (E)) begin n_mismatch++; \
   $display("[FAIL] %s expected %h seen %h", W, E, G); end end
module gso_regs_test;
   import gso_pkg::*;
   localparam int unsigned SETTLE = 20;
   localparam gso_word_t   MASK   = 16'hFFCE;  // undefined bits 0,4,5 ignored
   logic       mclk_i = 1'b0, rstn_i, sw_reset_i, reg_wr_i, reg_rd_i, reg_rvalid_o, config_done_i;
   logic       cycle_pct_step_i, meas_valid_i, alert_enable_i, analog_sense_pin_i;
   logic       current_alert_latching_i, voltage_alert_latching_i, temp_alert_latching_i;
   logic       charge_alert_latching_i, alert_output_pin_o, outputs_valid_o;
   logic [7:0] reg_addr_i;
   gso_word_t  reg_wdata_i, reg_rdata_o, est_cap_i, est_soc_i, est_fullcap_i, est_tte_i, est_ttf_i;
   gso_word_t  current_i, cell_voltage_reading_i, temp_i, rd, exp_f;
   gso_word_t  current_alert_limits_i, voltage_alert_limits_i, temperature_alert_limits_i;
   gso_word_t  charge_alert_limits_i;
   int         n_mismatch = 0, checks_done = 0, cycles = 0;
   logic [7:0] ofs [5] = '{`GSO_OFS_REPORTED_REMAINING_CAPACITY, `GSO_OFS_REPORTED_CHARGE_PERCENT, `GSO_OFS_FULLCAP, `GSO_OFS_TTE, `GSO_OFS_TTF};
   // ****************
   // harness
   // ****************
   always #4 mclk_i = ~mclk_i;
   gso_regs #(.VALID_CYC(SETTLE)) dut_u (.mclk_i, .rstn_i, .sw_reset_i, .reg_addr_i, .reg_wr_i, .reg_rd_i,
      .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .config_done_i, .est_cap_i, .est_soc_i, .est_fullcap_i,
      .est_tte_i, .est_ttf_i, .cycle_pct_step_i, .meas_valid_i, .current_i, .cell_voltage_reading_i,
      .temp_i, .current_alert_limits_i, .voltage_alert_limits_i, .temperature_alert_limits_i,
      .charge_alert_limits_i, .current_alert_latching_i, .voltage_alert_latching_i,
      .temp_alert_latching_i, .charge_alert_latching_i, .alert_enable_i, .analog_sense_pin_i,
      .alert_output_pin_o, .outputs_valid_o);
   gso_host_model host_u (.mclk_i(mclk_i), .reg_rdata_i(reg_rdata_o), .reg_rvalid_i(reg_rvalid_o),
      .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_wdata_o(reg_wdata_i));
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : complete_run
   task automatic tick(input int n);
      repeat (n) @(negedge mclk_i);
   endtask : tick
   task automatic status_is(input string w, input gso_word_t e);
      host_u.read_word(`GSO_OFS_STATUS, rd);
      `CHK(w, e & MASK, rd & MASK)
   endtask : status_is
   task automatic measure();
      @(negedge mclk_i);
      meas_valid_i = 1'b1;
      @(negedge mclk_i);
      meas_valid_i = 1'b0;
      tick(2);
   endtask : measure
   // whole run is well under a thousand cycles
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 4000) begin
         n_mismatch++;
         complete_run();
      end
   end
   // ****************
   // tests
   // ****************
   initial begin
      {rstn_i, sw_reset_i, config_done_i, cycle_pct_step_i, meas_valid_i, analog_sense_pin_i} = '0;
      {current_alert_latching_i, voltage_alert_latching_i, temp_alert_latching_i} = '0;
      {charge_alert_latching_i, alert_enable_i} = '0;
      {est_cap_i, est_soc_i, est_fullcap_i, est_tte_i, est_ttf_i} = {16'hFFFF, 16'h2080, 16'h0001, 16'hFFFF, 16'h8000};
      {current_i, cell_voltage_reading_i, temp_i} = {3{16'h2000}};
      {current_alert_limits_i, voltage_alert_limits_i, temperature_alert_limits_i} = {3{16'h4010}};
      charge_alert_limits_i = 16'h4010;
      tick(4);
      rstn_i = 1'b1;
      tick(4);
      status_is("status after reset", `GSO_STATUS_RST);
      host_u.read_word(`GSO_OFS_REPORTED_REMAINING_CAPACITY, rd);
      `CHK("capacity before valid", 16'h0000, rd)
      host_u.read_word(8'h01, rd);
      `CHK("unmapped read", 16'h0000, rd)
      host_u.write_word(`GSO_OFS_CYCLES, 16'h5555);
      host_u.read_word(`GSO_OFS_CYCLES, rd);
      `CHK("read-only cycles", 16'h0000, rd)
      host_u.write_word(`GSO_OFS_STATUS, 16'hFFFD);
      status_is("reset flag cleared", 16'h0000);
      @(negedge mclk_i) sw_reset_i = 1'b1;
      @(negedge mclk_i) sw_reset_i = 1'b0;
      status_is("reset flag on soft reset", 16'h0002);
      $display("test reset and refusals done");
      @(negedge mclk_i) config_done_i = 1'b1;
      @(negedge mclk_i) config_done_i = 1'b0;
      tick(SETTLE - 2);
      `CHK("valid too early", 1'b0, outputs_valid_o)
      tick(4);
      `CHK("valid after settle", 1'b1, outputs_valid_o)
      foreach (ofs[i]) begin
         host_u.read_word(ofs[i], rd);
         `CHK("estimation word", i == 0 ? est_cap_i : i == 1 ? est_soc_i : i == 2 ? est_fullcap_i :
              i == 3 ? est_tte_i : est_ttf_i, rd)
      end
      est_soc_i = 16'h20FF;
      status_is("no step within a percent", 16'h0002);
      est_soc_i = 16'h2100;
      status_is("step across a percent", 16'h0082);
      host_u.ack_events();
      $display("test settle and outputs done");
      repeat (100) begin
         @(negedge mclk_i) cycle_pct_step_i = 1'b1;
         @(negedge mclk_i) cycle_pct_step_i = 1'b0;
      end
      host_u.read_word(`GSO_OFS_CYCLES, rd);
      `CHK("one full cycle", 16'h0064, rd)
      analog_sense_pin_i = 1'b1;
      status_is("battery removed", 16'h8008);
      host_u.ack_events();
      analog_sense_pin_i = 1'b0;
      status_is("battery inserted", 16'h0800);
      host_u.ack_events();
      $display("test cycles and battery done");
      for (int lat = 0; lat < 2; lat++) begin
         for (int p = 0; p < 2; p++) begin
            {current_alert_latching_i, voltage_alert_latching_i, temp_alert_latching_i} = {3{lat[0]}};
            charge_alert_latching_i = lat[0];
            alert_enable_i          = lat[0];
            current_i               = p ? 16'h0500 : 16'h5000;
            cell_voltage_reading_i  = p ? 16'h5000 : 16'h0500;
            temp_i                  = p ? 16'h5000 : 16'hF000;
            charge_alert_limits_i   = p ? 16'h4030 : 16'h1000;
            exp_f                   = p ? 16'h3404 : 16'h4340;
            measure();
            status_is("flags beyond limits", exp_f);
            `CHK("alert pin", lat[0], alert_output_pin_o)
            {current_i, cell_voltage_reading_i, temp_i} = {3{16'h2000}};
            charge_alert_limits_i = 16'h4010;
            measure();
            status_is("flags back in range", lat ? exp_f : 16'h0000);
            host_u.write_word(`GSO_OFS_STATUS, 16'hBFFF);
            status_is("only zero bits clear", (lat ? exp_f : 16'h0000) & 16'hBFFF);
            host_u.write_word(`GSO_OFS_STATUS, 16'h0000);
            status_is("all flags cleared", 16'h0000);
            `CHK("alert pin released", 1'b0, alert_output_pin_o)
         end
      end
      $display("test alert groups done");
      complete_run();
   end
endmodule : gso_regs_test
